// ### rtl/rtc_i2c_slave.sv
`include "rtc_i2c_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module rtc_i2c_slave
(
	input wire logic sys_clk,
	input wire logic sys_rst,
	input wire logic link_clk,
	input wire logic scl_i,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_n,
	output logic [`RTC_PTR_W-1:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_we,
	output logic reg_re,
	input wire logic [7:0] reg_rdata
);

	// ----------------------------------------
	// link reset: async assert, release synced
	// ----------------------------------------
	logic [1:0] lrst_pipe;
	logic lrst;

	always_ff @(posedge link_clk or posedge sys_rst)
	begin
		if (sys_rst)
			lrst_pipe <= 2'h3;
		else
			lrst_pipe <= {lrst_pipe[0], 1'b0};
	end

	assign lrst = lrst_pipe[1];

	// ----------------------------------------
	// link domain
	// ----------------------------------------
	rtc_pkg::rtc_link_t l_reg;
	rtc_pkg::rtc_link_t l_next;
	rtc_pkg::rtc_sys_t s_reg;
	rtc_pkg::rtc_sys_t s_next;
	logic scl_rise;
	logic scl_fall;
	logic start_cond;
	logic stop_cond;

	// start/stop only when clock stayed high across the data edge
	assign scl_rise = l_reg.scl_f & ~l_reg.scl_p;
	assign scl_fall = ~l_reg.scl_f & l_reg.scl_p;
	assign start_cond = l_reg.scl_f & l_reg.scl_p & l_reg.sda_p &
		~l_reg.sda_f;
	assign stop_cond = l_reg.scl_f & l_reg.scl_p & ~l_reg.sda_p &
		l_reg.sda_f;

	always_comb
	begin
		l_next = l_reg;
		// three stages, a change counts once the last two agree
		l_next.scl_sy = {l_reg.scl_sy[1:0], scl_i};
		l_next.sda_sy = {l_reg.sda_sy[1:0], sda_i};
		if (l_reg.scl_sy[1] == l_reg.scl_sy[2])
			l_next.scl_f = l_reg.scl_sy[2];
		if (l_reg.sda_sy[1] == l_reg.sda_sy[2])
			l_next.sda_f = l_reg.sda_sy[2];
		l_next.scl_p = l_reg.scl_f;
		l_next.sda_p = l_reg.sda_f;
		l_next.ack_sy = {l_reg.ack_sy[1:0], s_reg.ack_tgl};
		// fetched byte is held stable by the system side
		if (l_reg.ack_sy[1] ^ l_reg.ack_sy[2])
			l_next.rbuf = s_reg.rdata;
		if (stop_cond)
		begin
			l_next.st = rtc_pkg::ST_IDLE;
			l_next.oe_n = 1'b1;
		end
		else if (start_cond)
		begin
			if (l_reg.st == rtc_pkg::ST_IDLE)
			begin
				l_next.st = rtc_pkg::ST_RX;
				l_next.first = 1'b1;
				l_next.cnt = 4'h0;
			end
			else
			begin
				// start inside a transfer ends it, no new addressing
				l_next.st = rtc_pkg::ST_IGN;
				l_next.oe_n = 1'b1;
			end
		end
		else
		begin
			case (l_reg.st)
				rtc_pkg::ST_RX:
				begin
					if (scl_rise)
					begin
						l_next.sh = {l_reg.sh[6:0], l_reg.sda_f};
						l_next.cnt = l_reg.cnt + 4'h1;
					end
					else if (scl_fall && l_reg.cnt == `RTC_BITS_PER_BYTE)
					begin
						l_next.cnt = 4'h0;
						l_next.first = 1'b0;
						l_next.st = rtc_pkg::ST_RXACK;
						l_next.oe_n = 1'b0;
						if (l_reg.first)
						begin
							if (l_reg.sh[7:1] != `RTC_SLAVE_ADDR)
							begin
								l_next.st = rtc_pkg::ST_IGN;
								l_next.oe_n = 1'b1;
							end
							else
							begin
								l_next.rw = l_reg.sh[0];
								l_next.ptr_byte = ~l_reg.sh[0];
								if (l_reg.sh[0])
								begin
									// prefetch at the current pointer
									l_next.req_tgl = ~l_reg.req_tgl;
									l_next.req_we = 1'b0;
									l_next.req_addr = l_reg.ptr;
								end
							end
						end
						else if (l_reg.ptr_byte)
						begin
							l_next.ptr = l_reg.sh[`RTC_PTR_W-1:0];
							l_next.ptr_byte = 1'b0;
						end
						else
						begin
							l_next.req_tgl = ~l_reg.req_tgl;
							l_next.req_we = 1'b1;
							l_next.req_addr = l_reg.ptr;
							l_next.req_wdata = l_reg.sh;
							l_next.ptr = l_reg.ptr + 4'h1;
						end
					end
				end
				rtc_pkg::ST_RXACK:
				begin
					if (scl_fall)
					begin
						l_next.oe_n = 1'b1;
						l_next.st = rtc_pkg::ST_RX;
						if (l_reg.rw)
						begin
							l_next.tx = {l_reg.rbuf[6:0], 1'b1};
							l_next.oe_n = l_reg.rbuf[7];
							l_next.ptr = l_reg.ptr + 4'h1;
							l_next.st = rtc_pkg::ST_TX;
						end
					end
				end
				rtc_pkg::ST_TX:
				begin
					if (scl_rise)
						l_next.cnt = l_reg.cnt + 4'h1;
					else if (scl_fall)
					begin
						if (l_reg.cnt == `RTC_BITS_PER_BYTE)
						begin
							l_next.cnt = 4'h0;
							l_next.oe_n = 1'b1;
							l_next.st = rtc_pkg::ST_TXACK;
							// next byte is fetched during the ack bit
							l_next.req_tgl = ~l_reg.req_tgl;
							l_next.req_we = 1'b0;
							l_next.req_addr = l_reg.ptr;
						end
						else
						begin
							l_next.oe_n = l_reg.tx[7];
							l_next.tx = {l_reg.tx[6:0], 1'b1};
						end
					end
				end
				rtc_pkg::ST_TXACK:
				begin
					if (scl_rise)
						l_next.acked = ~l_reg.sda_f;
					else if (scl_fall)
					begin
						if (l_reg.acked)
						begin
							l_next.tx = {l_reg.rbuf[6:0], 1'b1};
							l_next.oe_n = l_reg.rbuf[7];
							l_next.ptr = l_reg.ptr + 4'h1;
							l_next.st = rtc_pkg::ST_TX;
						end
						else
						begin
							l_next.st = rtc_pkg::ST_IGN;
							l_next.oe_n = 1'b1;
						end
					end
				end
				rtc_pkg::ST_IDLE:
					l_next.oe_n = 1'b1;
				rtc_pkg::ST_IGN:
					l_next.oe_n = 1'b1;
				default:
				begin
					l_next.st = rtc_pkg::ST_IGN;
					l_next.oe_n = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge link_clk or posedge lrst)
	begin
		if (lrst)
		begin
			l_reg <= '0;
			l_reg.scl_sy <= `RTC_SYNC_IDLE;
			l_reg.sda_sy <= `RTC_SYNC_IDLE;
			l_reg.scl_f <= 1'b1;
			l_reg.sda_f <= 1'b1;
			l_reg.scl_p <= 1'b1;
			l_reg.sda_p <= 1'b1;
			l_reg.st <= rtc_pkg::ST_IDLE;
			l_reg.oe_n <= 1'b1;
		end
		else
			l_reg <= l_next;
	end

	// open drain: only ever pulls low
	assign sda_o = 1'b0;
	assign sda_oe_n = l_reg.oe_n;

	// ----------------------------------------
	// system domain: register file access
	// ----------------------------------------
	always_comb
	begin
		s_next = s_reg;
		s_next.we = 1'b0;
		s_next.re = 1'b0;
		s_next.rq_sy = {s_reg.rq_sy[1:0], l_reg.req_tgl};
		if (s_reg.rd_pend)
		begin
			s_next.rdata = reg_rdata;
			s_next.rd_pend = 1'b0;
			s_next.ack_tgl = ~s_reg.ack_tgl;
		end
		// request fields are stable long before the toggle lands
		if (s_reg.rq_sy[1] ^ s_reg.rq_sy[2])
		begin
			s_next.addr = l_reg.req_addr;
			s_next.wdata = l_reg.req_wdata;
			if (l_reg.req_we)
				s_next.we = 1'b1;
			else
			begin
				s_next.re = 1'b1;
				s_next.rd_pend = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge sys_rst)
	begin
		if (sys_rst)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	assign reg_addr = s_reg.addr;
	assign reg_wdata = s_reg.wdata;
	assign reg_we = s_reg.we;
	assign reg_re = s_reg.re;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	property p_restart;
		@(posedge link_clk) disable iff (lrst)
		start_cond && !stop_cond && l_reg.st != rtc_pkg::ST_IDLE
		|=> l_reg.st == rtc_pkg::ST_IGN && l_reg.oe_n;
	endproperty
	a_restart: assert property (p_restart)
		else $error("repeated start not refused");

	property p_drive_only;
		@(posedge link_clk) disable iff (lrst)
		!l_reg.oe_n |-> l_reg.st inside {rtc_pkg::ST_RXACK, rtc_pkg::ST_TX};
	endproperty
	a_drive_only: assert property (p_drive_only)
		else $error("data driven outside ack or transmit");

	property p_first_byte;
		@(posedge link_clk) disable iff (lrst)
		start_cond && !stop_cond && l_reg.st == rtc_pkg::ST_IDLE
		|=> l_reg.st == rtc_pkg::ST_RX && l_reg.first && l_reg.cnt == 4'h0;
	endproperty
	a_first_byte: assert property (p_first_byte)
		else $error("start did not open address byte");

	property p_byte_end;
		@(posedge link_clk) disable iff (lrst)
		l_reg.st == rtc_pkg::ST_RX && scl_fall && !start_cond && !stop_cond
		&& l_reg.cnt == 4'h8
		|=> l_reg.st inside {rtc_pkg::ST_RXACK, rtc_pkg::ST_IGN}
		&& l_reg.cnt == 4'h0;
	endproperty
	a_byte_end: assert property (p_byte_end)
		else $error("byte did not end after eight bits");

	property p_ack_low;
		@(posedge link_clk) disable iff (lrst)
		l_reg.st == rtc_pkg::ST_RXACK |-> !l_reg.oe_n;
	endproperty
	a_ack_low: assert property (p_ack_low)
		else $error("ack released early");

	property p_nack_end;
		@(posedge link_clk) disable iff (lrst)
		l_reg.st == rtc_pkg::ST_TXACK && scl_fall && !l_reg.acked
		&& !start_cond && !stop_cond
		|=> l_reg.st == rtc_pkg::ST_IGN ##1 l_reg.oe_n;
	endproperty
	a_nack_end: assert property (p_nack_end)
		else $error("nack did not release line");

	property p_addr_match;
		@(posedge link_clk) disable iff (lrst)
		l_reg.st == rtc_pkg::ST_RX && l_reg.first && scl_fall
		&& l_reg.cnt == 4'h8 && !start_cond && !stop_cond
		|=> (l_reg.st == rtc_pkg::ST_RXACK) ==
		($past(l_reg.sh[7:1]) == 7'h68);
	endproperty
	a_addr_match: assert property (p_addr_match)
		else $error("address recognition wrong");

	property p_word_addr;
		@(posedge link_clk) disable iff (lrst)
		l_reg.st == rtc_pkg::ST_RX && !l_reg.first && l_reg.ptr_byte
		&& scl_fall && l_reg.cnt == 4'h8 && !start_cond && !stop_cond
		|=> l_reg.ptr == $past(l_reg.sh[3:0]) && !l_reg.ptr_byte;
	endproperty
	a_word_addr: assert property (p_word_addr)
		else $error("word address not taken");

	property p_ptr_inc;
		@(posedge link_clk) disable iff (lrst)
		l_reg.st == rtc_pkg::ST_RXACK && l_reg.rw && scl_fall
		&& !start_cond && !stop_cond
		|=> l_reg.ptr == $past(l_reg.ptr) + 4'h1
		&& l_reg.st == rtc_pkg::ST_TX;
	endproperty
	a_ptr_inc: assert property (p_ptr_inc)
		else $error("pointer not advanced on read");

	property p_stop;
		@(posedge link_clk) disable iff (lrst)
		stop_cond |=> l_reg.st == rtc_pkg::ST_IDLE && l_reg.oe_n;
	endproperty
	a_stop: assert property (p_stop)
		else $error("stop not honoured");

	property p_change_low;
		@(posedge link_clk) disable iff (lrst)
		$changed(l_reg.oe_n) && !$past(start_cond) && !$past(stop_cond)
		|-> !$past(l_reg.scl_f);
	endproperty
	a_change_low: assert property (p_change_low)
		else $error("data changed while clock high");

	property p_write_strobe;
		@(posedge sys_clk) disable iff (sys_rst)
		(s_reg.rq_sy[1] ^ s_reg.rq_sy[2]) && l_reg.req_we
		|=> reg_we && !reg_re ##1 !reg_we;
	endproperty
	a_write_strobe: assert property (p_write_strobe)
		else $error("write strobe missing");

	c_write: cover property (@(posedge sys_clk) disable iff (sys_rst)
		reg_we);
	c_read: cover property (@(posedge link_clk) disable iff (lrst)
		l_reg.st == rtc_pkg::ST_TXACK && scl_fall && l_reg.acked);
	c_nack: cover property (@(posedge link_clk) disable iff (lrst)
		l_reg.st == rtc_pkg::ST_TXACK ##1 l_reg.st == rtc_pkg::ST_IGN);
	c_foreign: cover property (@(posedge link_clk) disable iff (lrst)
		l_reg.st == rtc_pkg::ST_RX && l_reg.first
		##1 l_reg.st == rtc_pkg::ST_IGN);

endmodule

`default_nettype wire

// ### rtl/rtc_i2c_defines.svh
`ifndef RTC_I2C_DEFINES_SVH
`define RTC_I2C_DEFINES_SVH

// ----------------------------------------
// link constants
// ----------------------------------------
`define RTC_SLAVE_ADDR 7'h68
`define RTC_BITS_PER_BYTE 4'h8
`define RTC_PTR_W 4
`define RTC_SYNC_IDLE 3'h7

`endif

// ### rtl/rtc_pkg.sv
`include "rtc_i2c_defines.svh"

package rtc_pkg;

	// ----------------------------------------
	// link state machine
	// ----------------------------------------
	typedef enum logic [5:0]
	{
		ST_IDLE = 6'h01,
		ST_RX = 6'h02,
		ST_RXACK = 6'h04,
		ST_TX = 6'h08,
		ST_TXACK = 6'h10,
		ST_IGN = 6'h20
	} rtc_state_t;

	// ----------------------------------------
	// link domain state
	// ----------------------------------------
	typedef struct packed
	{
		logic [2:0] scl_sy;
		logic [2:0] sda_sy;
		logic scl_f;
		logic sda_f;
		logic scl_p;
		logic sda_p;
		rtc_state_t st;
		logic [3:0] cnt;
		logic [7:0] sh;
		logic [7:0] tx;
		logic first;
		logic ptr_byte;
		logic rw;
		logic acked;
		logic [`RTC_PTR_W-1:0] ptr;
		logic oe_n;
		logic req_tgl;
		logic req_we;
		logic [`RTC_PTR_W-1:0] req_addr;
		logic [7:0] req_wdata;
		logic [2:0] ack_sy;
		logic [7:0] rbuf;
	} rtc_link_t;

	// ----------------------------------------
	// system domain state
	// ----------------------------------------
	typedef struct packed
	{
		logic [2:0] rq_sy;
		logic we;
		logic re;
		logic rd_pend;
		logic [`RTC_PTR_W-1:0] addr;
		logic [7:0] wdata;
		logic [7:0] rdata;
		logic ack_tgl;
	} rtc_sys_t;

endpackage

// ### tb/rtc_i2c_master_model.sv
`timescale 1ns/100ps
`default_nettype none

module rtc_i2c_master_model
#(
	parameter int QTR = 25
)
(
	input wire logic sys_clk,
	input wire logic sda,
	output logic scl,
	output logic sda_rel
);
	// ----------------------------------------
	// bus master model
	// ----------------------------------------
	// both lines released: pull-up gives idle high
	initial
	begin
		scl = 1'b1;
		sda_rel = 1'b1;
	end

	task automatic qwait(input int n);
		repeat (n * QTR) @(negedge sys_clk);
	endtask

	// usable mid-transfer too, which makes it a repeated start
	task automatic start();
		qwait(1);
		sda_rel = 1'b1;
		qwait(1);
		scl = 1'b1;
		qwait(1);
		sda_rel = 1'b0;
		qwait(1);
		scl = 1'b0;
		qwait(1);
	endtask

	task automatic stop();
		qwait(1);
		sda_rel = 1'b0;
		qwait(1);
		scl = 1'b1;
		qwait(1);
		sda_rel = 1'b1;
		qwait(2);
	endtask

	// data moves a quarter after the fall, so the filter never sees it
	// change while the clock is still high
	task automatic clk_bit(input logic d, output logic s);
		qwait(1);
		sda_rel = d;
		qwait(1);
		scl = 1'b1;
		qwait(1);
		s = sda;
		qwait(1);
		scl = 1'b0;
	endtask

	// msb first, eight bits then the ack clock
	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			clk_bit(d[i], s);
		clk_bit(1'b1, s);
		ack = ~s;
	endtask

	// ack low for every byte but the last
	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			clk_bit(1'b1, s);
			d[i] = s;
		end
		clk_bit(~ack, s);
		qwait(1);
	endtask
endmodule

`default_nettype wire

// ### tb/rtc_i2c_slave_register_access_tb.sv
`include "rtc_i2c_defines.svh"
`timescale 1ns/100ps
`default_nettype none

module rtc_i2c_slave_register_access_tb;
	logic sys_clk;
	logic sys_rst;
	logic link_clk;
	logic scl;
	logic sda_rel;
	logic sda_o;
	logic sda_oe_n;
	logic [`RTC_PTR_W-1:0] reg_addr;
	logic [7:0] reg_wdata;
	logic reg_we;
	logic reg_re;
	logic [7:0] reg_rdata;
	logic [7:0] mem [16];
	wire logic sda;
	int bad_count;
	int comparisons;
	int cycles;
	int writes;
	int reads;

	// ----------------------------------------
	// clocks, bus and register stand-in
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end

	initial
	begin
		link_clk = 1'b0;
		#7;
		forever #62.5 link_clk = ~link_clk;
	end

	// wired-and with pull-up; the device can only pull low
	assign sda = sda_rel & (sda_oe_n | sda_o);
	assign reg_rdata = mem[reg_addr];

	always @(posedge sys_clk)
		if (reg_we)
		begin
			mem[reg_addr] <= reg_wdata;
			writes <= writes + 1;
		end

	// every fetch is counted, the discarded one after a nack too
	always @(posedge sys_clk)
		if (reg_re)
			reads <= reads + 1;

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (cycles == 50000)
		begin
			bad_count = bad_count + 1;
			report_and_stop();
		end
	end

	rtc_i2c_slave dut
	(
		.sys_clk(sys_clk),
		.sys_rst(sys_rst),
		.link_clk(link_clk),
		.scl_i(scl),
		.sda_i(sda),
		.sda_o(sda_o),
		.sda_oe_n(sda_oe_n),
		.reg_addr(reg_addr),
		.reg_wdata(reg_wdata),
		.reg_we(reg_we),
		.reg_re(reg_re),
		.reg_rdata(reg_rdata)
	);

	rtc_i2c_master_model m
	(
		.sys_clk(sys_clk),
		.sda(sda),
		.scl(scl),
		.sda_rel(sda_rel)
	);

	// ----------------------------------------
	// checking
	// ----------------------------------------
	task automatic check(input string what, input logic [7:0] seen,
		input logic [7:0] exp);
		comparisons = comparisons + 1;
		if (seen !== exp)
		begin
			bad_count = bad_count + 1;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic report_and_stop();
		if (bad_count == 0 && comparisons > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// word address ff: upper nibble dropped, pointer wraps f to 0
	task automatic t_write();
		logic a;
		int w0;
		w0 = writes;
		m.start();
		m.wr_byte(8'hd0, a);
		check("ack addr", a, 1'b1);
		m.wr_byte(8'hff, a);
		check("ack word", a, 1'b1);
		m.wr_byte(8'ha5, a);
		check("ack data0", a, 1'b1);
		m.wr_byte(8'h5a, a);
		check("ack data1", a, 1'b1);
		m.stop();
		check("writes", 8'(writes - w0), 8'h02);
		check("reg f", mem[15], 8'ha5);
		check("reg 0", mem[0], 8'h5a);
	endtask

	task automatic t_read_at();
		logic a;
		logic [7:0] d;
		m.start();
		m.wr_byte(8'hd0, a);
		m.wr_byte(8'h0f, a);
		check("ack ptr", a, 1'b1);
		m.stop();
		m.start();
		m.wr_byte(8'hd1, a);
		check("ack rd", a, 1'b1);
		m.rd_byte(1'b1, d);
		check("rd f", d, 8'ha5);
		m.rd_byte(1'b0, d);
		check("rd 0", d, 8'h5a);
		check("nack release", sda_oe_n, 1'b1);
		m.stop();
	endtask

	// no pointer write: carry on after the last byte read
	task automatic t_read_cur();
		logic a;
		logic [7:0] d;
		int r0;
		r0 = reads;
		m.start();
		m.wr_byte(8'hd1, a);
		m.rd_byte(1'b1, d);
		check("cur 1", d, 8'h31);
		m.rd_byte(1'b0, d);
		check("cur 2", d, 8'h32);
		m.stop();
		check("reads", 8'(reads - r0), 8'h03);
		check("rd addr", 8'(reg_addr), 8'h03);
	endtask

	task automatic t_foreign();
		logic a;
		logic [7:0] other [4] = '{8'hd2, 8'h50, 8'hd8, 8'he1};
		int w0;
		w0 = writes;
		foreach (other[i])
		begin
			m.start();
			m.wr_byte(other[i], a);
			check("ack foreign", a, 1'b0);
			m.wr_byte(8'h01, a);
			check("ack ignored", a, 1'b0);
			m.stop();
		end
		check("no write", 8'(writes - w0), 8'h00);
	endtask

	// repeated start ends the write; the word address still counts
	task automatic t_restart();
		logic a;
		logic [7:0] d;
		int w0;
		w0 = writes;
		m.start();
		m.wr_byte(8'hd0, a);
		m.wr_byte(8'h05, a);
		m.start();
		m.wr_byte(8'hd0, a);
		check("ack restart", a, 1'b0);
		m.wr_byte(8'h77, a);
		m.stop();
		check("restart write", 8'(writes - w0), 8'h00);
		m.start();
		m.wr_byte(8'hd1, a);
		check("ack after", a, 1'b1);
		m.rd_byte(1'b0, d);
		check("ptr kept", d, 8'h35);
		m.stop();
	endtask

	initial
	begin
		bad_count = 0;
		comparisons = 0;
		cycles = 0;
		writes = 0;
		reads = 0;
		sys_rst = 1'b1;
		for (int i = 0; i < 16; i++)
			mem[i] = 8'(8'h30 + i);
		repeat (10) @(negedge sys_clk);
		check("reset oe", sda_oe_n, 1'b1);
		sys_rst = 1'b0;
		repeat (100) @(negedge sys_clk);
		t_write();
		t_read_at();
		t_read_cur();
		t_foreign();
		t_restart();
		report_and_stop();
	end
endmodule

`default_nettype wire
